// File: include/wdog_pkg.sv
// Purpose: constants and types shared by the windowed watchdog block
// Assumes: classic wishbone slave with 8-bit registers at byte offsets
// Notes: period lengths are powers of two in oscillator cycles
package wdog_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 25;
  localparam logic [3:0] OFF_CONTROL = 4'h8;
  localparam logic [3:0] OFF_BYPASS_TEST = 4'h9;
  localparam logic [3:0] OFF_CLOCK_TEST = 4'ha;
  localparam logic [3:0] OFF_RESTART_KEY = 4'hb;
  localparam int unsigned BIT_WINDOWED = 7;
  localparam int unsigned BIT_DEBUG_STOP = 6;
  localparam int unsigned RATE_HI = 2;
  localparam logic [2:0] RATE_OFF = 3'h0;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] BYPASS_TEST_READ = 8'h00;
  localparam logic [7:0] CLOCK_TEST_READ = 8'h80;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_ARMED
  } key_state_t;
endpackage : wdog_pkg

// File: include/wdog_count_if.sv
// Purpose: carries counter control and status between control and counter
// Assumes: single clock domain
// Notes: restart is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface wdog_count_if;
  logic [2:0] rate;
  logic run;
  logic restart;
  logic in_window;
  logic expired;
  modport ctrl (output rate, output run, output restart, input in_window, input expired);
  modport cnt (input rate, input run, input restart, output in_window, output expired);
endinterface : wdog_count_if
`default_nettype wire

// File: design/wdog_counter.sv
// Purpose: time-out counter with period select and window detection
// Assumes: rate code nonzero while running
// Notes: expired pulses one cycle when the count reaches the period end
`timescale 1ns/1ps
`default_nettype none
module wdog_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  wdog_count_if.cnt cif
);
  logic [wdog_pkg::CNT_W-1:0] count;
  logic [wdog_pkg::CNT_W-1:0] next_count;
  logic expired_q;
  logic next_expired;

  // period length minus one in oscillator cycles
  function automatic logic [wdog_pkg::CNT_W-1:0] period_last(input logic [2:0] rate);
    logic [wdog_pkg::CNT_W-1:0] one;
    one = {{(wdog_pkg::CNT_W-1){1'b0}}, 1'b1};
    case (rate)
      3'h1: period_last = (one << 14) - one; // [RQ6]
      3'h2: period_last = (one << 16) - one;
      3'h3: period_last = (one << 18) - one;
      3'h4: period_last = (one << 20) - one;
      3'h5: period_last = (one << 22) - one;
      3'h6: period_last = (one << 23) - one;
      3'h7: period_last = (one << 24) - one;
      default: period_last = '0;
    endcase
  endfunction : period_last

  logic [wdog_pkg::CNT_W-1:0] last;
  assign last = period_last(cif.rate);
  // window opens at three quarters of the period
  assign cif.in_window = (count >= (last - (last >> 2))); // [RQ1]
  assign cif.expired = expired_q;

  always_comb begin
    next_count = count;
    next_expired = 1'b0;
    if (!cif.run || cif.restart) begin
      next_count = '0; // [RQ11]
    end else if (count == last) begin
      next_expired = 1'b1; // [RQ8]
      next_count = '0;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      expired_q <= 1'b0;
    end else if (ce_i) begin
      count <= next_count;
      expired_q <= next_expired;
    end
  end
endmodule : wdog_counter
`default_nettype wire

// File: design/windowed_watchdog_timer.sv
// Purpose: windowed watchdog timer with wishbone register access
// Assumes: clk_i is the oscillator clock; special_mode_i and debug_active_i are synchronous
// Notes: watchdog_reset_o is a one-cycle registered request to the reset generator
// Functional notes
// (RQ1) windowed mode: restart only in last quarter
// (RQ2) windowed early restart write causes reset
// (RQ3) repeated first keys accepted; second completes
// (RQ4) software waits for next window after restart
// (RQ5) debug stop halts watchdog and periodic timer
// (RQ6) rate field selects period, zero disables
// (RQ7) nonzero rate write enables, starts period
// (RQ8) time-out requests system reset
// (RQ9) mode and rate write-once in user mode
// (RQ10) debug stop bit write-once always
// (RQ11) period counted from latest completed restart
// (RQ12) restart register reads zero, always writable
// (RQ13) restart writes ignored while disabled
// (RQ14) bad key value resets immediately
// (RQ15) software writes first then second key
// (RQ16) repeated same keys tolerated
// (RQ17) bypass test register reads zero outside special
// (RQ18) clock test register reads 0x80 outside special
// (RQ19) reset leaves watchdog disabled
// (RQ20) each cause gives one registered reset pulse
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic special_mode_i,
  input wire logic debug_active_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [wdog_pkg::ADDR_W-1:0] adr_i,
  input wire logic [wdog_pkg::DATA_W-1:0] dat_i,
  input wire logic sel_i,
  output logic [wdog_pkg::DATA_W-1:0] dat_o,
  output logic ack_o,
  output logic watchdog_reset_o,
  output logic periodic_timer_stop_o
);
  logic windowed_mode;
  logic debug_stop;
  logic [2:0] rate_field;
  logic ctl_written;
  logic dbg_written;
  logic [7:0] bypass_test;
  logic [7:0] clock_test;
  wdog_pkg::key_state_t key_state;
  logic ack;
  logic [7:0] rdata;
  logic rst_req;

  logic next_windowed_mode;
  logic next_debug_stop;
  logic [2:0] next_rate_field;
  logic next_ctl_written;
  logic next_dbg_written;
  logic [7:0] next_bypass_test;
  logic [7:0] next_clock_test;
  wdog_pkg::key_state_t next_key_state;
  logic next_ack;
  logic [7:0] next_rdata;
  logic next_rst_req;
  logic restart_pulse;
  logic counter_ce;

  wdog_count_if cif ();

  function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
    hit = (adr == off);
  endfunction : hit

  logic access;
  logic wr;
  assign access = cyc_i && stb_i && !ack;
  assign wr = access && we_i && sel_i;

  // freezing the whole counter also freezes the periodic timer via the stop output
  assign periodic_timer_stop_o = debug_stop && debug_active_i; // [RQ5]
  assign counter_ce = ce_i && !(debug_stop && debug_active_i); // [RQ5]

  assign cif.rate = rate_field;
  assign cif.run = (rate_field != wdog_pkg::RATE_OFF);
  assign cif.restart = restart_pulse;

  wdog_counter u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(counter_ce),
    .cif(cif)
  );

  always_comb begin
    next_windowed_mode = windowed_mode;
    next_debug_stop = debug_stop;
    next_rate_field = rate_field;
    next_ctl_written = ctl_written;
    next_dbg_written = dbg_written;
    next_bypass_test = bypass_test;
    next_clock_test = clock_test;
    next_key_state = key_state;
    next_ack = access;
    next_rdata = wdog_pkg::READ_ZERO;
    next_rst_req = 1'b0;
    restart_pulse = 1'b0;

    if (access && !we_i) begin
      if (hit(adr_i, wdog_pkg::OFF_CONTROL)) begin
        next_rdata = {windowed_mode, debug_stop, 3'h0, rate_field};
      end else if (hit(adr_i, wdog_pkg::OFF_BYPASS_TEST)) begin
        next_rdata = special_mode_i ? bypass_test : wdog_pkg::BYPASS_TEST_READ; // [RQ17]
      end else if (hit(adr_i, wdog_pkg::OFF_CLOCK_TEST)) begin
        next_rdata = special_mode_i ? clock_test : wdog_pkg::CLOCK_TEST_READ; // [RQ18]
      end else begin
        next_rdata = wdog_pkg::READ_ZERO; // [RQ12]
      end
    end

    if (wr && hit(adr_i, wdog_pkg::OFF_CONTROL)) begin
      if (special_mode_i || !ctl_written) begin
        next_windowed_mode = dat_i[wdog_pkg::BIT_WINDOWED]; // [RQ9]
        next_rate_field = dat_i[wdog_pkg::RATE_HI:0]; // [RQ6]
        next_ctl_written = 1'b1;
        next_key_state = wdog_pkg::KEY_IDLE;
        restart_pulse = 1'b1; // [RQ7]
      end
      if (!dbg_written) begin
        next_debug_stop = dat_i[wdog_pkg::BIT_DEBUG_STOP]; // [RQ10]
        next_dbg_written = 1'b1;
      end
    end

    if (wr && special_mode_i && hit(adr_i, wdog_pkg::OFF_BYPASS_TEST)) begin
      next_bypass_test = dat_i; // [RQ17]
    end
    if (wr && special_mode_i && hit(adr_i, wdog_pkg::OFF_CLOCK_TEST)) begin
      next_clock_test = dat_i; // [RQ18]
    end

    // writes while disabled fall through with no effect
    if (wr && hit(adr_i, wdog_pkg::OFF_RESTART_KEY) && cif.run) begin // [RQ13]
      if (windowed_mode && !cif.in_window) begin
        next_rst_req = 1'b1; // [RQ2]
        next_key_state = wdog_pkg::KEY_IDLE;
      end else if (dat_i == wdog_pkg::KEY_FIRST) begin
        next_key_state = wdog_pkg::KEY_ARMED; // [RQ3] [RQ16]
      end else if (dat_i == wdog_pkg::KEY_SECOND) begin
        if (key_state == wdog_pkg::KEY_ARMED) begin
          restart_pulse = 1'b1; // [RQ11]
          next_key_state = wdog_pkg::KEY_IDLE;
        end
      end else begin
        next_rst_req = 1'b1; // [RQ14]
        next_key_state = wdog_pkg::KEY_IDLE;
      end
    end

    if (cif.expired) begin
      next_rst_req = 1'b1; // [RQ8]
      next_key_state = wdog_pkg::KEY_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      windowed_mode <= 1'b0;
      debug_stop <= 1'b0;
      rate_field <= wdog_pkg::RATE_OFF; // [RQ19]
      ctl_written <= 1'b0;
      dbg_written <= 1'b0;
      bypass_test <= wdog_pkg::BYPASS_TEST_READ;
      clock_test <= wdog_pkg::CLOCK_TEST_READ;
      key_state <= wdog_pkg::KEY_IDLE;
      ack <= 1'b0;
      rdata <= wdog_pkg::READ_ZERO;
      rst_req <= 1'b0;
    end else if (ce_i) begin
      windowed_mode <= next_windowed_mode;
      debug_stop <= next_debug_stop;
      rate_field <= next_rate_field;
      ctl_written <= next_ctl_written;
      dbg_written <= next_dbg_written;
      bypass_test <= next_bypass_test;
      clock_test <= next_clock_test;
      key_state <= next_key_state;
      ack <= next_ack;
      rdata <= next_rdata;
      rst_req <= next_rst_req; // [RQ20]
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;
  assign watchdog_reset_o = rst_req;
endmodule : windowed_watchdog_timer
`default_nettype wire

// File: dv/wdog_monitor.sv
// Purpose: port checker for the windowed watchdog
// Assumes: ce_i is held high by the bench
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module wdog_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic special_mode_i,
  input wire logic debug_active_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [7:0] dat_o,
  input wire logic ack_o,
  input wire logic watchdog_reset_o,
  input wire logic periodic_timer_stop_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd;
  // test registers read their fixed values only outside special mode
  assign rd = cyc_i && stb_i && !we_i && !ack_o && !special_mode_i;
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  property p_pulse; watchdog_reset_o |=> !watchdog_reset_o; endproperty
  property p_stop; periodic_timer_stop_o |-> debug_active_i; endproperty
  property p_lock; periodic_timer_stop_o ##1 debug_active_i |-> periodic_timer_stop_o; endproperty
  property p_key; rd && adr_i == 4'hb |=> dat_o == 8'h00; endproperty
  property p_byp; rd && adr_i == 4'h9 |=> dat_o == 8'h00; endproperty
  property p_ctt; rd && adr_i == 4'ha |=> dat_o == 8'h80; endproperty
  property p_wake; $fell(rst_i) |-> !watchdog_reset_o [*4]; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  a_pulse: assert property (p_pulse) else $error("reset request too long");
  a_stop: assert property (p_stop) else $error("stop without debug");
  a_lock: assert property (p_lock) else $error("stop bit lost");
  a_key: assert property (p_key) else $error("restart read nonzero");
  a_byp: assert property (p_byp) else $error("bypass read wrong");
  a_ctt: assert property (p_ctt) else $error("clock test read wrong");
  a_wake: assert property (p_wake) else $error("request after reset");
  c_rst: cover property (watchdog_reset_o);
  c_stop: cover property (periodic_timer_stop_o);
  c_wr: cover property (ack_o && we_i);
endmodule : wdog_monitor
bind windowed_watchdog_timer wdog_monitor wdog_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .special_mode_i(special_mode_i), .debug_active_i(debug_active_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .watchdog_reset_o(watchdog_reset_o), .periodic_timer_stop_o(periodic_timer_stop_o));
`default_nettype wire

// File: dv/tb_top.sv
// Purpose: self-checking bench for the windowed watchdog
// Assumes: rate code 1, so a period is 2^14 cycles
// Notes: every test but the time-out test starts from reset because control fields lock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sp = 1'b0;
  logic dbg = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] dat = 8'h00;
  logic [7:0] rdat, q;
  logic ack, wrst, pstop;
  int n_errors = 0;
  int checks = 0;
  int n, k, v;
  always #2.5 clk_i = ~clk_i;
  windowed_watchdog_timer windowed_watchdog_timer_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .special_mode_i(sp), .debug_active_i(dbg), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
    .adr_i(adr), .dat_i(dat), .sel_i(1'b1), .dat_o(rdat), .ack_o(ack),
    .watchdog_reset_o(wrst), .periodic_timer_stop_o(pstop));
  function automatic int per(input logic [2:0] r);
    int sh[8] = '{0, 14, 16, 18, 20, 22, 23, 24};
    return 1 << sh[r];
  endfunction : per
  // pipeline slack of a few cycles around the nominal expiry
  function automatic logic near(input int got, input int want);
    return got >= want - 8 && got <= want + 8;
  endfunction : near
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic boot(input logic s);
    rst_i <= 1'b1;
    sp <= s;
    dbg <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : boot
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 16 && ack !== 1'b1; i++) @(posedge clk_i);
    if (ack !== 1'b1) begin
      n_errors++;
      close_out();
    end
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : bus
  // n ends at hi + 1 when no reset request came
  task automatic await(input int hi);
    for (n = 0; n <= hi && wrst !== 1'b1; n++) @(posedge clk_i);
  endtask : await
  initial begin
    void'($urandom(32'h33e25017));
    boot(1'b0);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, 4'h9, 8'hff);
    bus(1'b0, 4'h9, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, 4'ha, 8'h00);
    bus(1'b0, 4'ha, 8'h00);
    chk(q, 8'h80);
    bus(1'b0, 4'h3, 8'h00);
    chk(q, 8'h00);
    bus(1'b1, 4'hb, 8'h3c);
    await(40);
    chk(n, 41);
    $display("reset values end");
    bus(1'b1, 4'h8, 8'h01);
    bus(1'b1, 4'h8, 8'hc7);
    bus(1'b0, 4'hb, 8'h00);
    chk(q, 8'h00);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 8'h01);
    dbg <= 1'b1;
    await(per(1) + 8);
    chk(pstop, 1'b0);
    chk(near(n, per(1) - 10), 1'b1);
    $display("time-out end");
    boot(1'b0);
    bus(1'b1, 4'h8, 8'h01);
    v = 11000 + $urandom % 1000;
    await(v);
    chk(n, v + 1);
    k = 1 + $urandom % 3;
    repeat (k) bus(1'b1, 4'hb, 8'h55);
    bus(1'b0, 4'h8, 8'h00); // unrelated access between the keys
    bus(1'b1, 4'hb, 8'haa);
    bus(1'b1, 4'hb, 8'haa);
    await(per(1) + 8);
    chk(near(n, per(1) - 4), 1'b1);
    $display("restart end");
    for (k = 0; k < 4; k++) begin
      v = (k == 0) ? 0 : $urandom % 256;
      if (v == 8'h55 || v == 8'haa) v = v ^ 1;
      boot(1'b0);
      bus(1'b1, 4'h8, 8'h01);
      bus(1'b1, 4'hb, 8'(v));
      await(2);
      chk(n <= 1, 1'b1);
    end
    $display("bad key end");
    boot(1'b0);
    bus(1'b1, 4'h8, 8'h81);
    v = 12400 + $urandom % 3000;
    await(v);
    chk(n, v + 1);
    bus(1'b1, 4'hb, 8'h55);
    bus(1'b1, 4'hb, 8'haa);
    await(2);
    chk(n, 3);
    // early write a careless program would make in the fresh period
    bus(1'b1, 4'hb, 8'h55);
    await(2);
    chk(n <= 1, 1'b1);
    $display("window end");
    boot(1'b0);
    bus(1'b1, 4'h8, 8'h41);
    dbg <= 1'b1;
    await(6000);
    chk(n, 6001);
    chk(pstop, 1'b1);
    bus(1'b1, 4'h8, 8'h01);
    bus(1'b0, 4'h8, 8'h00);
    chk(q, 8'h41);
    dbg <= 1'b0;
    await(per(1) + 8);
    chk(near(n, per(1) - 2), 1'b1);
    $display("debug stop end");
    boot(1'b1);
    for (k = 1; k < 8; k++) begin
      bus(1'b1, 4'h8, 8'(k));
      bus(1'b0, 4'h8, 8'h00);
      chk(q, k);
    end
    bus(1'b1, 4'h9, 8'h5a);
    bus(1'b0, 4'h9, 8'h00);
    chk(q, 8'h5a);
    bus(1'b1, 4'ha, 8'h3c);
    bus(1'b0, 4'ha, 8'h00);
    chk(q, 8'h3c);
    $display("special mode end");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
